// *** design/cso_params.svh ***
// Offsets, field positions, reset values and timing counts of the clock option block.
// Assumes a 250 MHz ref_clk and word-aligned APB byte addresses.
`ifndef CSO_PARAMS_SVH
`define CSO_PARAMS_SVH

// Register byte addresses
`define CSO_ADDR_MODE 12'h000
`define CSO_ADDR_STATUS 12'h004

// Mode register fields
`define CSO_MODE_STOP_BIT 0
`define CSO_MODE_WSEL_LO 1
`define CSO_MODE_WSEL_HI 2
`define CSO_MODE_RESET 32'h0000_0000

// Status register fields
`define CSO_ST_SRC_LO 0
`define CSO_ST_SRC_HI 1
`define CSO_ST_STOPPABLE 2
`define CSO_ST_READY 3
`define CSO_ST_WDT_EN 4
`define CSO_ST_TMR_EN 5

// Option source encodings
`define CSO_OPT_HIOSC 2'h0
`define CSO_OPT_XTAL 2'h1
`define CSO_OPT_EXT 2'h2

// Watchdog count clock selection naming the slow oscillator
`define CSO_WSEL_SLOW 2'h0

// Crystal stabilization wait
`define CSO_CLK_MHZ 250
`define CSO_STAB_NS 1000
`define CSO_STAB_CYC ((`CSO_STAB_NS * `CSO_CLK_MHZ + 999) / 1000)

`endif

// *** design/cso_pkg.sv ***
// Types shared by the clock option block.
// Assumes cso_params.svh supplies the numeric constants.
package cso_pkg;
	typedef enum logic [1:0] {
		CSO_SRC_HIOSC,
		CSO_SRC_XTAL,
		CSO_SRC_EXT
	} cso_src_e;

	typedef enum logic [1:0] {
		CSO_ST_CAPTURE,
		CSO_ST_WAIT,
		CSO_ST_RUN
	} cso_state_e;

	// 1 = pin released to its shared port function
	typedef struct packed {
		logic osc_in_shared_port;
		logic osc_out_shared_port;
		logic ext_clock_shared_port;
	} cso_port_rel_s;

	// Pins claimed for clocking
	typedef struct packed {
		logic osc_in_pin;
		logic osc_out_pin;
	} cso_osc_claim_s;

	// Gates on the slow clock and the main clock
	typedef struct packed {
		logic wdt_clk_en;
		logic wdt_force_slow;
		logic timer_slow_clk_en;
		logic slow_osc_run;
		logic sys_clk_ready;
	} cso_gate_s;
endpackage : cso_pkg

// *** design/cso_clock_option.sv ***
// Clock source option logic: pin claiming, slow clock gating, crystal wait, APB registers.
// Assumes option inputs and pause/stop levels come from logic on ref_clk.
// Option inputs must be settled before reset release; they pass no synchroniser.
`timescale 1ns/1ps
`default_nettype none
`include "cso_params.svh"

module cso_clock_option #(
	parameter int STAB_CYC = `CSO_STAB_CYC
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic [1:0] opt_clk_src,
	input wire logic opt_slow_stoppable,
	input wire logic cpu_pause,
	input wire logic cpu_stop,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output cso_pkg::cso_port_rel_s port_rel,
	output cso_pkg::cso_osc_claim_s osc_claim,
	output cso_pkg::cso_gate_s gate
);
	import cso_pkg::*;

	// The wait counter is 16 bits wide; a longer wait would end on a compare value cut to 16 bits
	if (STAB_CYC < 1 || STAB_CYC > 65535) begin : g_bad_stab
		$error("STAB_CYC out of range");
	end

	// Map the option encoding; unknown codes fall back to the internal oscillator
	function automatic cso_src_e decode_src(input logic [1:0] code);
		cso_src_e s;
		s = CSO_SRC_HIOSC;
		if (code == `CSO_OPT_XTAL) begin
			s = CSO_SRC_XTAL;
		end else if (code == `CSO_OPT_EXT) begin
			s = CSO_SRC_EXT;
		end
		return s;
	endfunction : decode_src

	// Status shows the latched source in the option's own encoding
	function automatic logic [1:0] encode_src(input cso_src_e s);
		logic [1:0] c;
		c = `CSO_OPT_HIOSC;
		if (s == CSO_SRC_XTAL) begin
			c = `CSO_OPT_XTAL;
		end else if (s == CSO_SRC_EXT) begin
			c = `CSO_OPT_EXT;
		end
		return c;
	endfunction : encode_src

	// Latched option, sequencer and mode register contents
	cso_state_e state;
	cso_src_e src;
	logic stoppable;
	logic [15:0] stab_cnt;
	logic slow_osc_stop_bit;
	logic [1:0] wdt_sel;

	// Option capture and crystal wait sequencer
	cso_state_e next_state;
	logic [15:0] next_stab_cnt;
	wire cso_src_e opt_src = decode_src(opt_clk_src);
	wire stab_done = (stab_cnt == 16'(STAB_CYC - 1));

	always_comb begin
		next_state = state;
		next_stab_cnt = stab_cnt;
		case (state)
			CSO_ST_CAPTURE: begin
				next_stab_cnt = 16'h0000;
				// Only the crystal needs settling time
				next_state = (opt_src == CSO_SRC_XTAL) ? CSO_ST_WAIT : CSO_ST_RUN;
			end
			CSO_ST_WAIT: begin
				next_stab_cnt = stab_cnt + 16'h0001;
				if (stab_done) begin
					next_state = CSO_ST_RUN;
				end
			end
			CSO_ST_RUN: next_state = CSO_ST_RUN;
			default: next_state = CSO_ST_CAPTURE;
		endcase
	end

	// Option is sampled in the capture state only; reset alone reopens it
	wire capture = (state == CSO_ST_CAPTURE);

	// Sequencer state and crystal wait count
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state <= CSO_ST_CAPTURE;
			stab_cnt <= 16'h0000;
		end else begin
			state <= next_state;
			stab_cnt <= next_stab_cnt;
		end
	end

	// Latched option; later changes on the option inputs wait for the next reset
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			src <= CSO_SRC_HIOSC;
			stoppable <= 1'b0;
		end else if (capture) begin
			src <= opt_src;
			stoppable <= opt_slow_stoppable;
		end
	end

	// APB decode; slave answers in the first access cycle
	// An unmapped word reads as zero and raises the error flag
	wire setup = psel && !penable;
	wire hit_mode = (paddr == `CSO_ADDR_MODE);
	wire hit_status = (paddr == `CSO_ADDR_STATUS);
	wire mapped = hit_mode || hit_status;
	wire wr_mode = psel && penable && pready && pwrite && hit_mode;

	// Pin ownership by latched source
	// External clock leaves the output pin free, so its shared port is given back
	wire is_xtal = (src == CSO_SRC_XTAL);
	wire is_ext = (src == CSO_SRC_EXT);
	wire running = (state == CSO_ST_RUN);
	cso_port_rel_s next_port_rel;
	cso_osc_claim_s next_osc_claim;
	assign next_osc_claim.osc_in_pin = running && (is_xtal || is_ext);
	assign next_osc_claim.osc_out_pin = running && is_xtal;
	// Until the option is known, every shared port stays unclaimed-but-closed
	assign next_port_rel.osc_in_shared_port = running && !is_xtal && !is_ext;
	assign next_port_rel.osc_out_shared_port = running && !is_xtal;
	assign next_port_rel.ext_clock_shared_port = running && !is_ext;

	// Slow clock gating; the stop bit has no effect when the oscillator is unstoppable
	// Gates read all zero in reset; for one cycle after release they show the unstoppable defaults, which
	// keep the watchdog counting rather than risk starving it
	wire wdt_sel_slow = (wdt_sel == `CSO_WSEL_SLOW);
	wire slow_run = !stoppable || !slow_osc_stop_bit;
	cso_gate_s next_gate;
	assign next_gate.slow_osc_run = slow_run;
	assign next_gate.wdt_force_slow = !stoppable;
	// When the oscillator is stoppable, pause and stop both starve the count clock, whatever the stop bit holds
	wire cpu_halted = cpu_pause || cpu_stop;
	// A count clock other than the slow oscillator is cut as well
	wire soft_wdt_en = !cpu_halted && wdt_sel_slow && slow_run;
	assign next_gate.wdt_clk_en = !stoppable ? 1'b1 : soft_wdt_en;
	assign next_gate.timer_slow_clk_en = slow_run;
	assign next_gate.sys_clk_ready = running;

	wire [31:0] mode_word = {29'h0, wdt_sel, slow_osc_stop_bit};
	wire [31:0] status_word = {26'h0, gate.timer_slow_clk_en, gate.wdt_clk_en, running,
		stoppable, encode_src(src)};
	wire [31:0] rd_word = hit_mode ? mode_word : (hit_status ? status_word : 32'h0);

	// APB answer: ready one cycle after setup, data held until the next setup
	// so a master that samples late still finds its word
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= setup;
			pslverr <= setup && !mapped; // Unmapped: error, write dropped
			if (setup) begin
				prdata <= rd_word;
			end
		end
	end

	// Mode register; written only at the edge that completes the access
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			slow_osc_stop_bit <= 1'(`CSO_MODE_RESET >> `CSO_MODE_STOP_BIT);
			wdt_sel <= `CSO_WSEL_SLOW;
		end else if (wr_mode) begin
			slow_osc_stop_bit <= pwdata[`CSO_MODE_STOP_BIT];
			wdt_sel <= pwdata[`CSO_MODE_WSEL_HI:`CSO_MODE_WSEL_LO];
		end
	end

	// Pin ownership; all zero until the sequencer runs
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			port_rel <= '0;
			osc_claim <= '0;
		end else begin
			port_rel <= next_port_rel;
			osc_claim <= next_osc_claim;
		end
	end

	// Clock gates, one cycle behind their inputs
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			gate <= '0;
		end else begin
			gate <= next_gate;
		end
	end
endmodule : cso_clock_option
`default_nettype wire

// *** dv/cso_checker.sv ***
// Checker on clock option pins, gates and wait.
// Assumes bind onto cso_clock_option.
`timescale 1ns/1ps
`default_nettype none
`include "cso_params.svh"
module cso_checker #(
	parameter int STAB_CYC = `CSO_STAB_CYC
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic cpu_pause,
	input wire logic cpu_stop,
	input wire cso_pkg::cso_port_rel_s port_rel,
	input wire cso_pkg::cso_osc_claim_s osc_claim,
	input wire cso_pkg::cso_gate_s gate
);
	import cso_pkg::*;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	// Cycles from reset release to the ready flag, saturating
	logic [17:0] up_cnt;
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			up_cnt <= 18'h00000;
		end else if (!gate.sys_clk_ready && up_cnt != 18'h3ffff) begin
			up_cnt <= up_cnt + 18'h00001;
		end
	end
	// Ready comes two cycles after release; only the crystal adds its wait
	sequence s_xtal_up; $rose(gate.sys_clk_ready) && osc_claim.osc_out_pin; endsequence
	sequence s_int_up; $rose(gate.sys_clk_ready) && !osc_claim.osc_out_pin; endsequence
	property p_xtal;
		osc_claim.osc_out_pin |-> !port_rel.osc_in_shared_port && !port_rel.osc_out_shared_port;
	endproperty
	a_xtal: assert property (p_xtal) else $error("crystal pins shared");
	property p_int;
		port_rel.osc_in_shared_port |-> osc_claim == 2'h0 && port_rel.osc_out_shared_port;
	endproperty
	a_int: assert property (p_int) else $error("internal source kept a pin");
	property p_ext; osc_claim == 2'h2 |-> port_rel == 3'h2; endproperty
	a_ext: assert property (p_ext) else $error("ext port not held");
	property p_force; gate.wdt_force_slow |-> gate.wdt_clk_en; endproperty
	a_force: assert property (p_force) else $error("forced clock off");
	property p_halt; !gate.wdt_force_slow && (cpu_pause || cpu_stop) |=> !gate.wdt_clk_en; endproperty
	a_halt: assert property (p_halt) else $error("count clock in halt");
	property p_timer; $rose(cpu_stop) && gate.slow_osc_run |=> gate.timer_slow_clk_en; endproperty
	a_timer: assert property (p_timer) else $error("timer clock lost");
	property p_wait_x; s_xtal_up |-> up_cnt == 18'(STAB_CYC + 2); endproperty
	a_wait_x: assert property (p_wait_x) else $error("no crystal wait");
	property p_wait_i; s_int_up |-> up_cnt == 18'h00002; endproperty
	a_wait_i: assert property (p_wait_i) else $error("needless wait");
	property p_hold; osc_claim != 2'h0 |=> $stable(osc_claim); endproperty
	a_hold: assert property (p_hold) else $error("claim changed");
endmodule : cso_checker
bind cso_clock_option cso_checker #(.STAB_CYC(STAB_CYC)) u_chk (.ref_clk(ref_clk), .nrst(nrst),
	.cpu_pause(cpu_pause),
	.cpu_stop(cpu_stop), .port_rel(port_rel), .osc_claim(osc_claim), .gate(gate));
`default_nettype wire

// *** dv/cso_osc_model.sv ***
// Crystal model on the oscillator input pin.
// Assumes osc_claim from the clock option block.
`timescale 1ns/1ps
`default_nettype none
module cso_osc_model (
	input wire logic ref_clk,
	input wire cso_pkg::cso_osc_claim_s osc_claim,
	output logic osc_wave
);
	import cso_pkg::*;
	logic [1:0] ph = 2'h0;
	always @(posedge ref_clk) ph <= ph + 2'h1;
	// Released pin shows a changing pattern, never a held level
	assign osc_wave = osc_claim.osc_in_pin ? ph[1] : ph[0];
endmodule : cso_osc_model
`default_nettype wire

// *** dv/test_clock_source_option_config.sv ***
// Self-checking bench for the clock option block.
// Assumes a 4-cycle crystal wait to keep runs short.
`timescale 1ns/1ps
`default_nettype none
`include "cso_params.svh"
module test_clock_source_option_config;
	import cso_pkg::*;
	logic ref_clk, nrst, opt_slow_stoppable, cpu_pause, cpu_stop, psel, penable, pwrite, pready;
	logic pslverr, err, osc_wave;
	logic [1:0] opt_clk_src;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	cso_port_rel_s port_rel;
	cso_osc_claim_s osc_claim;
	cso_gate_s gate;
	int n_fail = 0;
	int n_compared = 0;
	cso_clock_option #(.STAB_CYC(4)) dut (.ref_clk, .nrst, .opt_clk_src, .opt_slow_stoppable,
		.cpu_pause, .cpu_stop, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .port_rel, .osc_claim, .gate);
	cso_osc_model u_osc (.ref_clk, .osc_claim, .osc_wave);
	initial begin
		ref_clk = 1'h0;
		forever #2 ref_clk = ~ref_clk;
	end
	task chk(input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
			n_fail++;
		end
	endtask : chk
	// APB master; waits on pready, watchdog ends a hang
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'h1;
		do @(posedge ref_clk); while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	task gchk(input logic [4:0] e);
		repeat (2) @(posedge ref_clk);
		chk(gate, e);
	endtask : gchk
	// Option is flipped after release; the latched copy must win
	task rst(input logic [1:0] s, input logic st);
		nrst <= 1'h0;
		opt_clk_src <= s;
		opt_slow_stoppable <= st;
		repeat (6) @(posedge ref_clk);
		nrst <= 1'h1;
		repeat (3) @(posedge ref_clk);
		opt_clk_src <= ~s;
		opt_slow_stoppable <= ~st;
		repeat (12) @(posedge ref_clk);
	endtask : rst
	task sc_pins();
		logic [4:0] pe [4] = '{5'h1c, 5'h07, 5'h0a, 5'h1c};
		for (int i = 0; i < 4; i++) begin
			rst(i[1:0], 1'h1);
			chk({port_rel, osc_claim}, pe[i]);
			apb(1'h0, `CSO_ADDR_STATUS, 32'h0);
			chk(rd[3:0], {2'h3, (i == 3) ? 2'h0 : i[1:0]});
		end
	endtask : sc_pins
	task sc_gate();
		rst(2'h0, 1'h1);
		gchk(5'h17);
		cpu_pause <= 1'h1;
		gchk(5'h07);
		cpu_pause <= 1'h0;
		cpu_stop <= 1'h1;
		gchk(5'h07);
		cpu_stop <= 1'h0;
		apb(1'h1, `CSO_ADDR_MODE, 32'h2);
		gchk(5'h07);
		apb(1'h1, `CSO_ADDR_MODE, 32'h1);
		gchk(5'h01);
		apb(1'h0, `CSO_ADDR_MODE, 32'h0);
		chk(rd, 32'h1);
		apb(1'h0, 12'h008, 32'h0);
		chk(err, 1'h1);
		chk(rd, 32'h0);
	endtask : sc_gate
	task sc_unstop();
		rst(2'h2, 1'h0);
		apb(1'h1, `CSO_ADDR_MODE, 32'h5);
		cpu_stop <= 1'h1;
		gchk(5'h1f);
		cpu_stop <= 1'h0;
	endtask : sc_unstop
	task print_verdict();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : print_verdict
	initial begin
		{nrst, opt_slow_stoppable, cpu_pause, cpu_stop, psel, penable, pwrite} = 7'h0;
		{opt_clk_src, paddr, pwdata} = 46'h0;
		sc_pins();
		sc_gate();
		sc_unstop();
		print_verdict();
	end
	// Watchdog far beyond the fewer than two hundred cycles needed
	initial begin
		#20us;
		n_fail++;
		print_verdict();
	end
endmodule : test_clock_source_option_config
`default_nettype wire
